// >>> shared/lbx_pkg.sv
// package: opcode patterns, field positions, flag positions, cycle counts for the literal/bit-op executor
package lbx_pkg;
  localparam int unsigned LBX_IW = 12;
  localparam int unsigned LBX_DW = 8;
  localparam int unsigned LBX_AW = 5;
  localparam int unsigned LBX_BW = 3;
  // instruction word field positions
  localparam int unsigned LBX_OP_HI = 11;
  localparam int unsigned LBX_OP_LO = 8;
  localparam int unsigned LBX_LIT_HI = 7;
  localparam int unsigned LBX_BIT_HI = 7;
  localparam int unsigned LBX_BIT_LO = 5;
  localparam int unsigned LBX_ADR_HI = 4;
  localparam logic [3:0] LBX_OP_ANDLIT = 4'hE;
  localparam logic [3:0] LBX_OP_BCLR = 4'h4;
  localparam logic [3:0] LBX_OP_BSET = 4'h5;
  localparam logic [3:0] LBX_OP_BTSTZ = 4'h6;
  localparam int unsigned LBX_ZFLAG_POS = 2;
  localparam logic [7:0] LBX_ACC_RST = 8'hFF;
  localparam logic [7:0] LBX_STAT_RST = 8'h00;
  localparam int unsigned LBX_SKIP_CYCLES = 2;
  localparam int unsigned LBX_PLAIN_CYCLES = 1;

  typedef enum logic [2:0] {
    LBX_NONE = 3'h0,
    LBX_AND_LITERAL = 3'h1,
    LBX_BIT_CLEAR = 3'h2,
    LBX_BIT_SET = 3'h3,
    LBX_BIT_TEST_Z = 3'h4
  } lbx_op_e;

  typedef struct packed {
    lbx_op_e op;
    logic [7:0] literal;
    logic [4:0] file_addr;
    logic [2:0] bit_num;
  } lbx_dec_s;

  typedef struct packed {
    logic we;
    logic [4:0] addr;
    logic [7:0] data;
  } lbx_fwr_s;
endpackage : lbx_pkg

// >>> design/lbx_decode.sv
// module: combinational instruction-word decoder for the four handled opcodes
`timescale 1ns/1ps
module lbx_decode (
  input wire logic [11:0] i_instr,
  output lbx_pkg::lbx_dec_s o_dec
);
  // ==========================================================
  // field split
  always_comb begin
    o_dec.literal = i_instr[lbx_pkg::LBX_LIT_HI:0];
    o_dec.bit_num = i_instr[lbx_pkg::LBX_BIT_HI:lbx_pkg::LBX_BIT_LO];
    o_dec.file_addr = i_instr[lbx_pkg::LBX_ADR_HI:0];
    unique case (i_instr[lbx_pkg::LBX_OP_HI:lbx_pkg::LBX_OP_LO])
      lbx_pkg::LBX_OP_ANDLIT: o_dec.op = lbx_pkg::LBX_AND_LITERAL;
      lbx_pkg::LBX_OP_BCLR: o_dec.op = lbx_pkg::LBX_BIT_CLEAR;
      lbx_pkg::LBX_OP_BSET: o_dec.op = lbx_pkg::LBX_BIT_SET;
      lbx_pkg::LBX_OP_BTSTZ: o_dec.op = lbx_pkg::LBX_BIT_TEST_Z;
      default: o_dec.op = lbx_pkg::LBX_NONE;
    endcase
  end
endmodule : lbx_decode

// >>> design/lbx_exec.sv
// module: execute stage for literal AND, bit clear, bit set and bit test with skip
// Functional notes
// - AND literal into accumulator, zero flag only
// - clear selected file bit, others kept
// - set selected file bit, others kept
// - five-bit file address, three-bit bit number
// - bit test skips next when bit zero
// - skipped word replaced by no-op, two cycles
`timescale 1ns/1ps
module lbx_exec (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_instr_valid,
  input wire logic [11:0] i_instr,
  input wire logic [7:0] i_file_rdata,
  output logic [4:0] o_file_raddr,
  output lbx_pkg::lbx_fwr_s o_file_wr,
  output logic [7:0] o_acc,
  output logic [7:0] o_status,
  output logic o_squash,
  output logic o_retire
);
  lbx_pkg::lbx_dec_s dec;
  logic [7:0] acc_reg;
  logic [7:0] acc_next;
  logic [7:0] stat_reg;
  logic skip_reg;
  logic [7:0] bit_mask;
  logic live;
  logic [7:0] and_res;
  logic [7:0] wdata_next;
  logic tested_zero;
  // slot accounting for the checks below
  logic test_open_reg;
  logic test_zero_reg;
  logic [1:0] test_slots_reg;
  logic [7:0] zflag_mask;

  lbx_decode u_dec (
    .i_instr(i_instr),
    .o_dec(dec)
  );

  // ==========================================================
  // operand selection
  assign o_file_raddr = dec.file_addr;
  assign bit_mask = 8'h01 << dec.bit_num;
  // instruction in the no-op slot after a skip is discarded
  assign live = i_instr_valid && !skip_reg;
  assign and_res = acc_reg & dec.literal;
  assign tested_zero = (i_file_rdata & bit_mask) == 8'h00;
  // every status bit but the zero flag must stay put
  assign zflag_mask = 8'h01 << lbx_pkg::LBX_ZFLAG_POS;

  // ==========================================================
  // accumulator
  always_comb begin
    acc_next = acc_reg;
    if (live && dec.op == lbx_pkg::LBX_AND_LITERAL) begin
      acc_next = and_res;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      acc_reg <= lbx_pkg::LBX_ACC_RST;
    end else begin
      acc_reg <= acc_next;
    end
  end

  // ==========================================================
  // status: only the zero flag moves, and only on the literal AND
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      stat_reg <= lbx_pkg::LBX_STAT_RST;
    end else if (live && dec.op == lbx_pkg::LBX_AND_LITERAL) begin
      stat_reg[lbx_pkg::LBX_ZFLAG_POS] <= (and_res == 8'h00);
    end
  end

  // ==========================================================
  // read-modify-write of the file register
  always_comb begin
    wdata_next = i_file_rdata;
    if (dec.op == lbx_pkg::LBX_BIT_CLEAR) begin
      wdata_next = i_file_rdata & ~bit_mask;
    end else if (dec.op == lbx_pkg::LBX_BIT_SET) begin
      wdata_next = i_file_rdata | bit_mask;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_file_wr <= '0;
    end else begin
      o_file_wr.we <= live && (dec.op == lbx_pkg::LBX_BIT_CLEAR || dec.op == lbx_pkg::LBX_BIT_SET);
      o_file_wr.addr <= dec.file_addr;
      o_file_wr.data <= wdata_next;
    end
  end

  // ==========================================================
  // skip control
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      skip_reg <= 1'b0;
    end else if (i_instr_valid) begin
      skip_reg <= live && dec.op == lbx_pkg::LBX_BIT_TEST_Z && tested_zero;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_retire <= 1'b0;
    end else begin
      o_retire <= live;
    end
  end

  // ==========================================================
  // slot accounting for the bit test: its own slot, plus the no-op slot after a skip
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      test_open_reg <= 1'b0;
      test_zero_reg <= 1'b0;
      test_slots_reg <= 2'h0;
    end else if (live) begin
      test_open_reg <= dec.op == lbx_pkg::LBX_BIT_TEST_Z;
      test_zero_reg <= tested_zero;
      test_slots_reg <= 2'(lbx_pkg::LBX_PLAIN_CYCLES);
    end else if (i_instr_valid && test_open_reg && test_slots_reg != 2'h3) begin
      // saturates so a stuck squash cannot wrap back to a legal count
      test_slots_reg <= test_slots_reg + 2'h1;
    end
  end

  assign o_acc = acc_reg;
  assign o_status = stat_reg;
  assign o_squash = skip_reg;

  // ==========================================================
  // checks
  sequence s_test_zero;
    live && dec.op == lbx_pkg::LBX_BIT_TEST_Z && tested_zero;
  endsequence

  sequence s_noop_slot;
    o_squash && !o_file_wr.we;
  endsequence

  a_and_result: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    live && dec.op == lbx_pkg::LBX_AND_LITERAL |=> o_acc == ($past(acc_reg) & $past(dec.literal)))
    else $error("literal and gave wrong accumulator");
  a_and_zflag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    live && dec.op == lbx_pkg::LBX_AND_LITERAL |=> o_status[lbx_pkg::LBX_ZFLAG_POS] == (o_acc == 8'h00))
    else $error("zero flag wrong after literal and");
  a_clear_bit: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    live && dec.op == lbx_pkg::LBX_BIT_CLEAR |=> o_file_wr.we && o_file_wr.data == ($past(i_file_rdata) & ~$past(bit_mask)))
    else $error("bit clear wrote wrong data");
  a_set_bit: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    live && dec.op == lbx_pkg::LBX_BIT_SET |=> o_file_wr.we && o_file_wr.data == ($past(i_file_rdata) | $past(bit_mask)))
    else $error("bit set wrote wrong data");
  a_write_addr: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_file_wr.we |-> o_file_wr.addr == $past(i_instr[4:0]))
    else $error("write address not taken from address field");
  a_skip_taken: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    s_test_zero ##1 i_instr_valid |-> s_noop_slot ##1 !o_retire)
    else $error("zero bit did not skip next instruction");
  a_noop_slot: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_squash && i_instr_valid |=> !o_retire && o_acc == $past(o_acc) && !o_file_wr.we)
    else $error("skipped instruction had an effect");
  a_flags_kept: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    live && dec.op inside {lbx_pkg::LBX_BIT_CLEAR, lbx_pkg::LBX_BIT_SET, lbx_pkg::LBX_BIT_TEST_Z}
    |=> o_status == $past(o_status))
    else $error("bit op changed status");
  a_one_bit_one: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    live && dec.op == lbx_pkg::LBX_BIT_TEST_Z && !tested_zero |=> !o_squash)
    else $error("set bit caused a skip");

  // ==========================================================
  // checks on slot timing and on what each instruction leaves alone
  // bit test whose bit reads one: no skip, one slot
  sequence s_test_one;
    live && dec.op == lbx_pkg::LBX_BIT_TEST_Z && !tested_zero;
  endsequence

  a_squash_once: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_squash && i_instr_valid |=> !o_squash)
    else $error("no-op slot lasted more than one word");
  a_squash_stall: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_squash && !i_instr_valid |=> o_squash)
    else $error("pending skip lost during a stall");
  a_squash_source: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $rose(o_squash) |-> $past(live) && $past(dec.op) == lbx_pkg::LBX_BIT_TEST_Z && $past(tested_zero))
    else $error("skip raised without a zero bit test");
  a_skip_two_slots: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    s_test_zero ##1 i_instr_valid ##1 i_instr_valid |-> live)
    else $error("word after the no-op slot was not executed");
  a_test_slots: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    live && test_open_reg
    |-> test_slots_reg == (test_zero_reg ? lbx_pkg::LBX_SKIP_CYCLES : lbx_pkg::LBX_PLAIN_CYCLES))
    else $error("bit test took the wrong number of slots");
  a_test_one_slot: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    s_test_one ##1 i_instr_valid |-> live)
    else $error("set bit test took more than one slot");
  a_test_no_effect: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    live && dec.op == lbx_pkg::LBX_BIT_TEST_Z |=> !o_file_wr.we && $stable(o_acc))
    else $error("bit test changed a register");
  a_write_source: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_file_wr.we |-> $past(live)
    && $past(dec.op) inside {lbx_pkg::LBX_BIT_CLEAR, lbx_pkg::LBX_BIT_SET})
    else $error("file write without a bit clear or set");
  a_one_bit_moved: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_file_wr.we |-> $onehot0(o_file_wr.data ^ $past(i_file_rdata)))
    else $error("file write changed more than one bit");
  a_acc_only_and: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !(live && dec.op == lbx_pkg::LBX_AND_LITERAL) |=> $stable(o_acc))
    else $error("accumulator changed without a literal and");
  a_zflag_only: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    1'b1 |=> ((o_status ^ $past(o_status)) & ~zflag_mask) == 8'h00)
    else $error("status bit other than zero flag changed");
endmodule : lbx_exec

// >>> verif/lbx_file_model.sv
// file register space model: combinational read, write on the write pulse
`timescale 1ns/1ps
module lbx_file_model (
  input wire logic i_clk_sys,
  input wire logic [4:0] i_raddr,
  input wire lbx_pkg::lbx_fwr_s i_wr,
  output logic [7:0] o_rdata
);
  logic [7:0] mem_reg [32];
  initial begin
    foreach (mem_reg[i]) mem_reg[i] = 8'h0F;
  end
  assign o_rdata = mem_reg[i_raddr];
  always @(posedge i_clk_sys) begin
    if (i_wr.we) begin
      mem_reg[i_wr.addr] <= i_wr.data;
    end
  end
endmodule : lbx_file_model

// >>> verif/literal_and_bit_ops_exec_bench.sv
// self-checking bench for the literal and bit-op executor
`timescale 1ns/1ps
module literal_and_bit_ops_exec_bench;
  logic clk, rst_n, vld, sq_o, ret, sq;
  logic [11:0] ins;
  logic [7:0] rd, acc, st, ea, es;
  logic [7:0] sh [32];
  logic [4:0] ra;
  lbx_pkg::lbx_fwr_s fw;
  int fail_count, checked;
  // rows: expected squash above the instruction word
  logic [12:0] rows [10] = '{13'h0E5F, 13'h0407, 13'h05E7, 13'h06E7, 13'h16C7,
    13'h05FF, 13'h041F, 13'h0000, 13'h0F00, 13'h063F};
  lbx_exec u_dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_instr_valid(vld), .i_instr(ins), .i_file_rdata(rd),
    .o_file_raddr(ra), .o_file_wr(fw), .o_acc(acc), .o_status(st), .o_squash(sq_o), .o_retire(ret));
  lbx_file_model u_mem (.i_clk_sys(clk), .i_raddr(ra), .i_wr(fw), .o_rdata(rd));
  // ==========================================
  // tasks
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic stop_test();
    if (fail_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  // one word in execute for one cycle, then one idle cycle
  task automatic exec(input logic [11:0] w, input logic esq);
    logic [7:0] d;
    logic ew;
    d = sh[w[4:0]];
    ew = !sq && (w[11:9] == 3'h2);
    d[w[7:5]] = w[8];
    if (!sq && w[11:8] == lbx_pkg::LBX_OP_ANDLIT) begin
      ea = ea & w[7:0];
      es = (ea == 8'h00) ? 8'h04 : 8'h00;
    end
    @(posedge clk);
    #1 ins = w;
    vld = 1'b1;
    @(posedge clk);
    #1 vld = 1'b0;
    chk(ra, w[4:0]);
    chk({fw.we, ret, sq_o}, {ew, !sq, esq && !sq});
    chk({acc, st}, {ea, es});
    if (ew) begin
      chk(fw[12:0], {w[4:0], d});
      sh[w[4:0]] = d;
    end
    sq = esq && !sq;
  endtask : exec
  // ==========================================
  // clock, watchdog, sequence
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #100000 fail_count++;
    stop_test();
  end
  initial begin
    rst_n = 1'b0;
    vld = 1'b0;
    ins = 12'h000;
    sq = 1'b0;
    ea = lbx_pkg::LBX_ACC_RST;
    es = lbx_pkg::LBX_STAT_RST;
    foreach (sh[i]) sh[i] = 8'h0F;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    foreach (rows[i]) exec(rows[i][11:0], rows[i][12]);
    // stall keeps a pending skip, then the word is dropped
    exec(12'h6C7, 1'b1);
    repeat (3) @(posedge clk);
    #1 chk(sq_o, 1'b1);
    exec(12'h5E8, 1'b0);
    // back-to-back words: skip, dropped word, live set, one-slot test, literal and
    @(posedge clk);
    #1 ins = 12'h6C7;
    vld = 1'b1;
    @(posedge clk);
    #1 ins = 12'h5E8;
    chk({ret, sq_o}, 2'h3);
    @(posedge clk);
    #1 chk({fw.we, ret, sq_o}, 3'h0);
    @(posedge clk);
    #1 ins = 12'h6E7;
    chk(fw[13:0], {1'b1, 5'h08, 8'h8F});
    sh[8] = 8'h8F;
    @(posedge clk);
    #1 ins = 12'hEF0;
    chk({ret, sq_o}, 2'h2);
    @(posedge clk);
    #1 vld = 1'b0;
    ea = ea & 8'hF0;
    es = (ea == 8'h00) ? 8'h04 : 8'h00;
    chk({acc, st}, {ea, es});
    // reset in mid-run with a skip pending
    exec(12'h6C7, 1'b1);
    rst_n = 1'b0;
    @(posedge clk);
    #1 rst_n = 1'b1;
    chk({acc, st, fw.we, ret, sq_o}, {lbx_pkg::LBX_ACC_RST, lbx_pkg::LBX_STAT_RST, 3'h0});
    sq = 1'b0;
    ea = lbx_pkg::LBX_ACC_RST;
    es = lbx_pkg::LBX_STAT_RST;
    exec(12'hE00, 1'b0);
    stop_test();
  end
endmodule : literal_and_bit_ops_exec_bench
